/* File: design/hdlc_msgbuf_pkg.sv */
// Constants and carriers for the HDLC message buffer port
//
// Overview of operation
// - Buffer zero writes feed outgoing frame
// - Sent transmit bytes cannot be read back
// - Receive pointer names buffer after end
// - Buffer zero reads return received message
// - Each port access advances byte position, unless a same-cycle receive end resets it
// - Buffer one has its own port
// - Buffer one mirrors buffer zero, 96 bytes
package hdlc_msgbuf_pkg;

    // Printed register indices; byte address is four times the index
    localparam logic [15:0] IDX_BUF_ZERO  = 16'h0600;
    localparam logic [15:0] IDX_BUF_ONE   = 16'h0700;
    localparam logic [15:0] IDX_SELECT    = 16'h011b;
    localparam logic [15:0] IDX_MSG_CTRL  = 16'h0120;
    localparam logic [15:0] IDX_TX_CNT0   = 16'h0114;
    localparam logic [15:0] IDX_TX_CNT1   = 16'h0144;
    localparam logic [15:0] IDX_TX_CNT2   = 16'h0154;
    localparam logic [15:0] IDX_RX_CNT0   = 16'h0115;
    localparam logic [15:0] IDX_RX_CNT1   = 16'h0145;
    localparam logic [15:0] IDX_RX_CNT2   = 16'h0155;

    localparam logic [15:0] ADDR_BUF_ZERO = IDX_BUF_ZERO << 2;
    localparam logic [15:0] ADDR_BUF_ONE  = IDX_BUF_ONE << 2;
    localparam logic [15:0] ADDR_SELECT   = IDX_SELECT << 2;
    localparam logic [15:0] ADDR_MSG_CTRL = IDX_MSG_CTRL << 2;
    localparam logic [15:0] ADDR_TX_CNT [3] = '{IDX_TX_CNT0 << 2, IDX_TX_CNT1 << 2,
                                                IDX_TX_CNT2 << 2};
    localparam logic [15:0] ADDR_RX_CNT [3] = '{IDX_RX_CNT0 << 2, IDX_RX_CNT1 << 2,
                                                IDX_RX_CNT2 << 2};

    localparam int unsigned BUF_BYTES     = 96;
    localparam int unsigned TX_FIFO_DEPTH = 32;
    localparam logic [6:0]  POS_LAST      = 7'h5f;
    localparam logic [6:0]  POS_RESET     = 7'h00;
    localparam logic [1:0]  SEL_RESET     = 2'h0;
    localparam logic [1:0]  CTRL_LAST     = 2'h2;
    localparam int unsigned FLAG_BIT      = 7;

    typedef struct packed {
        logic [1:0] ctrl;
        logic       bufSel;
        logic       last;
        logic [6:0] pos;
        logic [7:0] data;
    } txEntry_s;

    typedef struct packed {
        logic [1:0] ctrl;
        logic       bufSel;
        logic       eot;
        logic [7:0] data;
    } rxByte_s;

endpackage : hdlc_msgbuf_pkg

/* File: design/msg_fifo.sv */
// First-word-fall-through FIFO with registered head
`timescale 1ns/1ns
module msg_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      inValid,
    output logic                           inReady,
    input  wire logic [WIDTH-1:0]          inData,
    output logic                           outValid,
    input  wire logic                      outReady,
    output logic [WIDTH-1:0]               outData,
    output logic [$clog2(DEPTH+1)-1:0]     level
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [PW-1:0]    rdPtr_d;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : nextPtr

    assign inReady = (count_q != CW'(DEPTH));
    assign push    = inValid && inReady;
    assign pop     = outValid && outReady;
    assign level   = count_q;

    always_comb
    begin
        rdPtr_d = pop ? nextPtr(rdPtr_q) : rdPtr_q;
        count_d = CW'(count_q + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wrPtr_q] <= inData;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wrPtr_q <= nextPtr(wrPtr_q);
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // Head register; bypass covers a push into an empty queue
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            outValid <= 1'b0;
            outData  <= '0;
        end
        else
        begin
            outValid <= (count_d != '0);
            outData  <= (push && wrPtr_q == rdPtr_d) ? inData : mem[rdPtr_d];
        end
    end

endmodule : msg_fifo

/* File: design/hdlc_msgbuf_port.sv */
// APB access port to the HDLC message buffers
`timescale 1ns/1ns
module hdlc_msgbuf_port (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [15:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          txValid,
    input  wire logic                     txReady,
    output hdlc_msgbuf_pkg::txEntry_s     txEntry,
    input  wire logic [5:0]               txBusy,
    input  wire logic                     rxValid,
    output logic                          rxReady,
    input  wire hdlc_msgbuf_pkg::rxByte_s rxByte,
    output logic                          rxEndOfTransferIrq
);
    logic [1:0]               selQ;
    logic [6:0]               posQ [2];
    logic                     rxPtrQ [3];
    logic                     access;
    logic                     done;
    logic                     isBuf0;
    logic                     isBuf1;
    logic                     isPort;
    logic                     isSel;
    logic                     isCtrl;
    logic [2:0]               isTxCnt;
    logic [2:0]               isRxCnt;
    logic                     mapped;
    logic                     commitReq;
    logic                     txPush;
    logic                     txInReady;
    logic                     selChange;
    logic                     rxAcc;
    logic                     rxEotAcc;
    logic [2:0]               rxIdx;
    logic [1:0]               posReset;
    logic [5:0]               rxInReady;
    logic [5:0]               rxOutValid;
    logic [5:0]               rxPop;
    logic [7:0]               rxOutData [6];
    logic [6:0]               rxLevel [6];
    hdlc_msgbuf_pkg::txEntry_s txEntryD;

    // Address decode
    always_comb
    begin
        isBuf0 = (paddr == hdlc_msgbuf_pkg::ADDR_BUF_ZERO);
        isBuf1 = (paddr == hdlc_msgbuf_pkg::ADDR_BUF_ONE);
        isSel  = (paddr == hdlc_msgbuf_pkg::ADDR_SELECT);
        isCtrl = (paddr == hdlc_msgbuf_pkg::ADDR_MSG_CTRL);
        for (int c = 0; c < 3; c++)
        begin
            isTxCnt[c] = (paddr == hdlc_msgbuf_pkg::ADDR_TX_CNT[c]);
            isRxCnt[c] = (paddr == hdlc_msgbuf_pkg::ADDR_RX_CNT[c]);
        end
    end

    assign isPort    = isBuf0 || isBuf1;
    assign mapped    = isPort || isSel || isCtrl || (|isTxCnt) || (|isRxCnt);
    assign access    = psel && penable;
    assign commitReq = isCtrl && (|pwdata[1:0]);

    // A full transmit queue stalls the write rather than losing bytes
    assign pready  = !(access && pwrite && (isPort || commitReq) && !txInReady);
    assign done    = access && pready;
    assign pslverr = access && !mapped;

    // Port writes become frame bytes; commit marks the message end
    always_comb
    begin
        txEntryD        = '0;
        txEntryD.ctrl   = selQ;
        txEntryD.bufSel = isPort ? isBuf1 : !pwdata[0];
        txEntryD.last   = isCtrl;
        txEntryD.pos    = posQ[txEntryD.bufSel];
        txEntryD.data   = isPort ? pwdata[7:0] : 8'h00;
    end

    // Only writes push; transmit bytes leave with no copy kept
    assign txPush = done && pwrite && (isPort || commitReq);

    msg_fifo #(
        .WIDTH ($bits(hdlc_msgbuf_pkg::txEntry_s)),
        .DEPTH (hdlc_msgbuf_pkg::TX_FIFO_DEPTH)
    ) txQueue (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (txPush),
        .inReady  (txInReady),
        .inData   (txEntryD),
        .outValid (txValid),
        .outReady (txReady),
        .outData  (txEntry),
        .level    ()
    );

    // Controller select; codes above the last controller are ignored
    assign selChange = done && pwrite && isSel && (pwdata[1:0] <= hdlc_msgbuf_pkg::CTRL_LAST)
                       && (pwdata[1:0] != selQ);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            selQ <= hdlc_msgbuf_pkg::SEL_RESET;
        else if (selChange)
            selQ <= pwdata[1:0];
    end

    // Receive side: one queue per controller and buffer
    assign rxIdx    = {rxByte.ctrl, rxByte.bufSel};
    assign rxReady  = (rxByte.ctrl <= hdlc_msgbuf_pkg::CTRL_LAST) ? rxInReady[rxIdx] : 1'b1;
    assign rxAcc    = rxValid && rxReady && (rxByte.ctrl <= hdlc_msgbuf_pkg::CTRL_LAST);
    assign rxEotAcc = rxAcc && rxByte.eot;

    for (genvar i = 0; i < 6; i++)
    begin : gRx
        // Reading a port pops the selected controller's queue
        assign rxPop[i] = done && !pwrite && isPort && ({selQ, isBuf1} == 3'(i));

        msg_fifo #(
            .WIDTH (8),
            .DEPTH (hdlc_msgbuf_pkg::BUF_BYTES)
        ) rxQueue (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .inValid  (rxValid && rxIdx == 3'(i)),
            .inReady  (rxInReady[i]),
            .inData   (rxByte.data),
            .outValid (rxOutValid[i]),
            .outReady (rxPop[i]),
            .outData  (rxOutData[i]),
            .level    (rxLevel[i])
        );
    end

    // Receive pointer names the buffer holding the finished message
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int c = 0; c < 3; c++)
                rxPtrQ[c] <= 1'b0;
            rxEndOfTransferIrq <= 1'b0;
        end
        else
        begin
            if (rxEotAcc)
                rxPtrQ[rxByte.ctrl] <= rxByte.bufSel;
            rxEndOfTransferIrq <= rxEotAcc;
        end
    end

    // Byte positions, one per buffer port
    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            posReset[b] = selChange
                          || (done && pwrite && commitReq && (pwdata[0] ? b == 0 : b == 1))
                          || (rxEotAcc && rxByte.ctrl == selQ && rxByte.bufSel == 1'(b));
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            posQ[0] <= hdlc_msgbuf_pkg::POS_RESET;
            posQ[1] <= hdlc_msgbuf_pkg::POS_RESET;
        end
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                if (posReset[b])
                    posQ[b] <= hdlc_msgbuf_pkg::POS_RESET;
                else if (done && isPort && isBuf1 == 1'(b))
                    posQ[b] <= (posQ[b] == hdlc_msgbuf_pkg::POS_LAST) ?
                               hdlc_msgbuf_pkg::POS_RESET : 7'(posQ[b] + 7'h01);
            end
        end
    end

    // Read data; an empty receive queue reads as zero
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (isPort && rxOutValid[{selQ, isBuf1}])
            prdata[7:0] = rxOutData[{selQ, isBuf1}];
        else if (isSel)
            prdata[1:0] = selQ;
        for (int c = 0; c < 3; c++)
        begin
            if (isTxCnt[c])
            begin
                // Buffer zero is offered whenever it is idle
                prdata[hdlc_msgbuf_pkg::FLAG_BIT] = txBusy[2*c];
                prdata[6:0] = (2'(c) == selQ) ? posQ[txBusy[2*c]] : 7'h00;
            end
            if (isRxCnt[c])
            begin
                prdata[hdlc_msgbuf_pkg::FLAG_BIT] = rxPtrQ[c];
                prdata[6:0] = rxLevel[2*c + int'(rxPtrQ[c])];
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence zeroWriteDone;
        done && pwrite && isBuf0;
    endsequence

    sequence oneWriteDone;
        done && pwrite && isBuf1;
    endsequence

    sequence portReadDone;
        done && !pwrite && isPort;
    endsequence

    a_buf_zero_push: assert property (zeroWriteDone |-> txPush && !txEntryD.bufSel
        && txEntryD.data == pwdata[7:0] && txEntryD.ctrl == selQ ##1 txValid)
        else $error("buffer zero write did not reach transmit queue");

    a_buf_one_push: assert property (oneWriteDone |-> txPush && txEntryD.bufSel
        && txEntryD.pos == posQ[1] ##1 txValid)
        else $error("buffer one write did not reach transmit queue");

    a_write_stall: assert property (access && pwrite && isPort && !txInReady
        |-> !pready)
        else $error("port write accepted while transmit queue full");

    a_no_readback: assert property (portReadDone |-> !txPush)
        else $error("port read disturbed transmit queue");

    a_read_data: assert property (portReadDone and (rxOutValid[{selQ, isBuf1}]
        && !rxValid) |-> prdata[7:0] == rxOutData[{selQ, isBuf1}]
        ##1 rxLevel[$past({selQ, isBuf1})] == 7'($past(rxLevel[{selQ, isBuf1}]) - 7'h01))
        else $error("port read did not return and remove head byte");

    a_pos_advance: assert property (done && isBuf0 && !posReset[0]
        |=> posQ[0] == (($past(posQ[0]) == 7'h5f) ? 7'h00 : 7'($past(posQ[0]) + 7'h01)))
        else $error("buffer zero position did not advance");

    a_pos_bound: assert property (posQ[0] <= 7'h5f && posQ[1] <= 7'h5f)
        else $error("byte position beyond 96 bytes");

    a_pos_restart: assert property (selChange |=> posQ[0] == 7'h00 && posQ[1] == 7'h00
        && selQ == $past(pwdata[1:0]))
        else $error("position not restarted on reselect");

    a_rx_pointer: assert property (rxEotAcc |=> rxEndOfTransferIrq
        && rxPtrQ[$past(rxByte.ctrl)] == $past(rxByte.bufSel) ##1 !rxEndOfTransferIrq
        || $past(rxEotAcc))
        else $error("receive pointer or end pulse wrong");

endmodule : hdlc_msgbuf_port

/* File: sim/testbench.sv */
// Self-checking bench for the HDLC message buffer port
`timescale 1ns/1ns
module testbench;
    localparam int LIMIT = 20000;
    logic                     clk_sys = 1'b0;
    logic                     rst     = 1'b1;
    logic                     psel    = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite  = 1'b0;
    logic [15:0]              paddr   = 16'h0000;
    logic [31:0]              pwdata  = 32'h00000000;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     txValid;
    logic                     txReady = 1'b0;
    hdlc_msgbuf_pkg::txEntry_s txEntry;
    logic [5:0]               txBusy  = 6'h00;
    logic                     rxValid = 1'b0;
    logic                     rxReady;
    hdlc_msgbuf_pkg::rxByte_s rxByte  = 12'h000;
    logic                     rxEndOfTransferIrq;
    hdlc_msgbuf_pkg::txEntry_s txq[$];
    logic [31:0]              rdv;
    logic                     errv;
    logic                     wrDone  = 1'b0;
    int                       numErrors  = 0;
    int                       checkCount = 0;
    int                       irqCount   = 0;
    int                       cycles     = 0;
    logic [11:0]              expTx[7] = '{12'h4a0, 12'h4a1, 12'h4a2, 12'h500,
                                           12'h6b0, 12'h6b1, 12'h700};
    logic [6:0]               expPos[7] = '{7'h00, 7'h01, 7'h02, 7'h00, 7'h00, 7'h01, 7'h00};

    hdlc_msgbuf_port i_hdlc_msgbuf_port (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txValid(txValid), .txReady(txReady), .txEntry(txEntry),
        .txBusy(txBusy), .rxValid(rxValid), .rxReady(rxReady), .rxByte(rxByte),
        .rxEndOfTransferIrq(rxEndOfTransferIrq)
    );

    always #25 clk_sys = ~clk_sys;

    // Sampled mid-cycle, where every launched value has settled
    always @(negedge clk_sys)
    begin
        if (txValid === 1'b1 && txReady === 1'b1)
            txq.push_back(txEntry);
        if (rxEndOfTransferIrq === 1'b1)
            irqCount++;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            numErrors++;
            endSim();
        end
    end

    task automatic endSim;
        $display("errors %0d checks %0d", numErrors, checkCount);
        if (numErrors == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : endSim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Request held until the rising edge that sees pready; data taken there
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [7:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        rdv     = prdata;
        errv    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdChk(input logic [15:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 8'h00);
        chk(rdv, exp);
    endtask : rdChk

    task automatic rxPush(input hdlc_msgbuf_pkg::rxByte_s v);
        @(posedge clk_sys);
        rxValid <= 1'b1;
        rxByte  <= v;
        forever
        begin
            @(posedge clk_sys);
            if (rxReady === 1'b1)
                break;
        end
        rxValid <= 1'b0;
        rxByte  <= ~v;
    endtask : rxPush

    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[0], 32'h0);
        rdChk(hdlc_msgbuf_pkg::ADDR_RX_CNT[0], 32'h0);
        apb(1'b0, 16'h0ffc, 8'h00);
        chk({rdv[30:0], errv}, 32'h1);
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_SELECT, 8'h01);
        for (int i = 0; i < 3; i++)
            apb(1'b1, hdlc_msgbuf_pkg::ADDR_BUF_ZERO, 8'ha0 + i[7:0]);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h03);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[0], 32'h00);
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_MSG_CTRL, 8'h01);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h00);
        for (int i = 0; i < 2; i++)
            apb(1'b1, hdlc_msgbuf_pkg::ADDR_BUF_ONE, 8'hb0 + i[7:0]);
        txBusy <= 6'h04;
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h82);
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_MSG_CTRL, 8'h02);
        txBusy  <= 6'h00;
        txReady <= 1'b1;
        while (txq.size() < 7)
            @(posedge clk_sys);
        for (int i = 0; i < 7; i++)
        begin
            chk({txq[i].ctrl, txq[i].bufSel, txq[i].last, txq[i].data}, expTx[i]);
            if (!txq[i].last)
                chk(txq[i].pos, expPos[i]);
        end
        rdChk(hdlc_msgbuf_pkg::ADDR_BUF_ZERO, 32'h0);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h01);
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_SELECT, 8'h02);
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_SELECT, 8'h01);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h00);
        // Transmitter stalls: the queue fills, then the next write must wait
        txReady <= 1'b0;
        txq.delete();
        for (int i = 0; i < hdlc_msgbuf_pkg::TX_FIFO_DEPTH; i++)
            apb(1'b1, hdlc_msgbuf_pkg::ADDR_BUF_ZERO, i[7:0]);
        fork
            begin
                apb(1'b1, hdlc_msgbuf_pkg::ADDR_BUF_ZERO, 8'h20);
                wrDone = 1'b1;
            end
            begin
                repeat (10) @(posedge clk_sys);
                chk(wrDone, 1'b0);
                txReady <= 1'b1;
            end
        join
        while (txq.size() < 33)
            @(posedge clk_sys);
        chk({txq[32].pos, txq[32].data}, {7'h20, 8'h20});
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_MSG_CTRL, 8'h01);
        for (int i = 0; i < 95; i++)
            apb(1'b1, hdlc_msgbuf_pkg::ADDR_BUF_ZERO, i[7:0]);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h5f);
        apb(1'b1, hdlc_msgbuf_pkg::ADDR_BUF_ZERO, 8'h5f);
        rdChk(hdlc_msgbuf_pkg::ADDR_TX_CNT[1], 32'h00);
        for (int i = 0; i < 4; i++)
            rxPush({2'h1, 1'b0, i == 3, 8'hc0 + i[7:0]});
        repeat (2) @(posedge clk_sys);
        chk(irqCount, 1);
        rdChk(hdlc_msgbuf_pkg::ADDR_RX_CNT[1], 32'h04);
        for (int i = 0; i < 4; i++)
            rdChk(hdlc_msgbuf_pkg::ADDR_BUF_ZERO, 32'hc0 + i);
        for (int i = 0; i < 2; i++)
            rxPush({2'h1, 1'b1, i == 1, 8'hd0 + i[7:0]});
        repeat (2) @(posedge clk_sys);
        chk(irqCount, 2);
        rdChk(hdlc_msgbuf_pkg::ADDR_RX_CNT[1], 32'h82);
        for (int i = 0; i < 2; i++)
            rdChk(hdlc_msgbuf_pkg::ADDR_BUF_ONE, 32'hd0 + i);
        endSim();
    end
endmodule : testbench
